// ===== verilog/attr_setup_defs.vh
`ifndef ATTR_SETUP_DEFS_VH
`define ATTR_SETUP_DEFS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define ADDR_MIP_LEVEL_START    16'hb530
`define ADDR_TEXEL_VERT_START   16'hb534
`define ADDR_TEXEL_HORIZ_START  16'hb538
`define ADDR_GREEN_BLUE_X_DELTA 16'hb53c
`define ADDR_ALPHA_RED_X_DELTA  16'hb540
`define ADDR_GREEN_BLUE_Y_DELTA 16'hb544
`define ADDR_ALPHA_RED_Y_DELTA  16'hb548
`define ADDR_GREEN_BLUE_START   16'hb54c
`define ADDR_ALPHA_RED_START    16'hb550
`define ADDR_DEPTH_X_DELTA      16'hb554
`define ADDR_DEPTH_Y_DELTA      16'hb558
`define ADDR_DEPTH_START        16'hb55c
`define ADDR_ATTR_CONTROL       16'hb600
`define ADDR_ATTR_STATUS        16'hb604

// ----------------------------------------------------------------------------
// storage indices
// ----------------------------------------------------------------------------
`define NUM_SETUP_REGS          12
`define IDX_MIP_LEVEL_START     0
`define IDX_TEXEL_VERT_START    1
`define IDX_TEXEL_HORIZ_START   2
`define IDX_GREEN_BLUE_X_DELTA  3
`define IDX_ALPHA_RED_X_DELTA   4
`define IDX_GREEN_BLUE_Y_DELTA  5
`define IDX_ALPHA_RED_Y_DELTA   6
`define IDX_GREEN_BLUE_START    7
`define IDX_ALPHA_RED_START     8
`define IDX_DEPTH_X_DELTA       9
`define IDX_DEPTH_Y_DELTA       10
`define IDX_DEPTH_START         11

// ----------------------------------------------------------------------------
// fields and values
// ----------------------------------------------------------------------------
`define RESET_VALUE             32'h0000_0000
`define CTRL_WRAP_EN_BIT        26
`define CTRL_CMD_MSB            30
`define CTRL_CMD_LSB            27
`define CMD_PERSPECTIVE_A       4'h5
`define CMD_PERSPECTIVE_B       4'h6
`define MIP_WRAP_MSB            30
`define MIP_WRAP_LSB            27
`define MIP_INT_MSB             26
`define MIP_INT_LSB             19
`define PERSP_INT_MSB           30
`define PERSP_INT_LSB           7
`define LINEAR_INT_MSB          30
`define LINEAR_INT_LSB          19
`define LINEAR_FILT_MSB         18
`define LINEAR_FILT_LSB         11
`define RESP_OKAY               2'h0
`define RESP_SLVERR             2'h2

`endif

// ===== verilog/attr_setup_regs.v
`timescale 1ns/1ns
`include "attr_setup_defs.vh"

module attr_setup_regs #(
  parameter ADDR_W = 16,
  parameter LANES  = 8
) (
  input  wire                clk,
  input  wire                reset_n,
  input  wire [ADDR_W-1:0]   s_axi_awaddr,
  input  wire                s_axi_awvalid,
  output reg                 s_axi_awready,
  input  wire [31:0]         s_axi_wdata,
  input  wire [3:0]          s_axi_wstrb,
  input  wire                s_axi_wvalid,
  output reg                 s_axi_wready,
  output reg  [1:0]          s_axi_bresp,
  output reg                 s_axi_bvalid,
  input  wire                s_axi_bready,
  input  wire [ADDR_W-1:0]   s_axi_araddr,
  input  wire                s_axi_arvalid,
  output reg                 s_axi_arready,
  output reg  [31:0]         s_axi_rdata,
  output reg  [1:0]          s_axi_rresp,
  output reg                 s_axi_rvalid,
  input  wire                s_axi_rready,
  input  wire [31:0]         mip_x_delta,
  input  wire [31:0]         mip_y_delta,
  input  wire [31:0]         vert_x_delta,
  input  wire [31:0]         vert_y_delta,
  input  wire [31:0]         horiz_x_delta,
  input  wire [31:0]         horiz_y_delta,
  input  wire                attr_load,
  input  wire                attr_x_step,
  input  wire                attr_y_step,
  output reg  [7:0]          mip_level,
  output reg  [3:0]          mip_wrap_limit,
  output reg  [23:0]         texel_vert_coord,
  output reg  [7:0]          texel_vert_filter,
  output reg  [23:0]         texel_horiz_coord,
  output reg  [7:0]          texel_horiz_filter,
  output reg  [15:0]         blue_value,
  output reg  [15:0]         green_value,
  output reg  [15:0]         red_value,
  output reg  [15:0]         alpha_value,
  output reg  [31:0]         depth_value,
  output reg                 perspective_active
);

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  function [31:0] sext16;
    input [15:0] half;
    begin
      sext16 = {{16{half[15]}}, half};
    end
  endfunction

  function [31:0] merge_bytes;
    input [31:0] old_word;
    input [31:0] new_word;
    input [3:0]  strobe;
    integer      b;
    begin
      merge_bytes = old_word;
      for (b = 0; b < 4; b = b + 1) begin
        if (strobe[b]) begin
          merge_bytes[b*8 +: 8] = new_word[b*8 +: 8];
        end
      end
    end
  endfunction

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  reg  [31:0]       setup_reg [0:`NUM_SETUP_REGS-1];
  reg  [31:0]       attr_control;
  reg  [15:0]       x_step_count;
  reg  [15:0]       y_step_count;
  reg  [ADDR_W-1:0] aw_addr;
  reg  [31:0]       w_data;
  reg  [3:0]        w_strb;

  wire [ADDR_W-1:0] base_addr = `ADDR_MIP_LEVEL_START;
  wire [ADDR_W-1:0] last_addr = `ADDR_DEPTH_START;
  wire [ADDR_W-1:0] ctrl_addr = `ADDR_ATTR_CONTROL;
  wire [ADDR_W-1:0] stat_addr = `ADDR_ATTR_STATUS;

  wire [ADDR_W-1:0] wr_off    = aw_addr - base_addr;
  wire [ADDR_W-1:0] rd_off    = s_axi_araddr - base_addr;
  wire [3:0]        wr_idx    = wr_off[5:2];
  wire [3:0]        rd_idx    = rd_off[5:2];
  wire              wr_setup  = (aw_addr >= base_addr) && (aw_addr <= last_addr);
  wire              rd_setup  = (s_axi_araddr >= base_addr) && (s_axi_araddr <= last_addr);
  wire              wr_ctrl   = (aw_addr == ctrl_addr);
  wire              rd_ctrl   = (s_axi_araddr == ctrl_addr);
  wire              rd_stat   = (s_axi_araddr == stat_addr);

  wire [3:0]        cmd_code  = attr_control[`CTRL_CMD_MSB:`CTRL_CMD_LSB];
  wire              wrap_en   = attr_control[`CTRL_WRAP_EN_BIT];
  wire              persp     = (cmd_code == `CMD_PERSPECTIVE_A) ||
                                (cmd_code == `CMD_PERSPECTIVE_B);

  // both address and data held, response not yet issued
  wire              do_write  = !s_axi_awready && !s_axi_wready && !s_axi_bvalid;

  integer i;

  // --------------------------------------------------------------------------
  // axi4-lite write channel
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `RESP_OKAY;
      aw_addr       <= {ADDR_W{1'b0}};
      w_data        <= `RESET_VALUE;
      w_strb        <= 4'h0;
      attr_control  <= `RESET_VALUE;
      for (i = 0; i < `NUM_SETUP_REGS; i = i + 1) begin
        setup_reg[i] <= `RESET_VALUE;
      end
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr       <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data       <= s_axi_wdata;
        w_strb       <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        if (wr_setup && (aw_addr[1:0] == 2'b00)) begin
          // halves of colour words and s-formats are stored as written
          setup_reg[wr_idx] <= merge_bytes(setup_reg[wr_idx],
                                           w_data, w_strb);
          s_axi_bresp       <= `RESP_OKAY;
        end else if (wr_ctrl) begin
          attr_control <= merge_bytes(attr_control, w_data, w_strb);
          s_axi_bresp  <= `RESP_OKAY;
        end else begin
          s_axi_bresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // axi4-lite read channel
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= `RESET_VALUE;
      s_axi_rresp   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rresp   <= `RESP_OKAY;
        if (rd_setup && (s_axi_araddr[1:0] == 2'b00)) begin
          s_axi_rdata <= setup_reg[rd_idx];
        end else if (rd_ctrl) begin
          s_axi_rdata <= attr_control;
        end else if (rd_stat) begin
          s_axi_rdata <= {y_step_count, x_step_count};
        end else begin
          s_axi_rdata <= `RESET_VALUE;
          s_axi_rresp <= `RESP_SLVERR;
        end
      end
      if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid  <= 1'b0;
        s_axi_arready <= 1'b1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // lane sources: 0 mip, 1 vert, 2 horiz, 3 blue, 4 green, 5 red, 6 alpha,
  // 7 depth
  // --------------------------------------------------------------------------
  wire [31:0] gb_dx = setup_reg[`IDX_GREEN_BLUE_X_DELTA];
  wire [31:0] ar_dx = setup_reg[`IDX_ALPHA_RED_X_DELTA];
  wire [31:0] gb_dy = setup_reg[`IDX_GREEN_BLUE_Y_DELTA];
  wire [31:0] ar_dy = setup_reg[`IDX_ALPHA_RED_Y_DELTA];
  wire [31:0] gb_st = setup_reg[`IDX_GREEN_BLUE_START];
  wire [31:0] ar_st = setup_reg[`IDX_ALPHA_RED_START];

  wire [32*LANES-1:0] start_bus = {
    setup_reg[`IDX_DEPTH_START],
    sext16(ar_st[31:16]), sext16(ar_st[15:0]),
    sext16(gb_st[31:16]), sext16(gb_st[15:0]),
    setup_reg[`IDX_TEXEL_HORIZ_START],
    setup_reg[`IDX_TEXEL_VERT_START],
    setup_reg[`IDX_MIP_LEVEL_START]
  };
  wire [32*LANES-1:0] dx_bus = {
    setup_reg[`IDX_DEPTH_X_DELTA],
    sext16(ar_dx[31:16]), sext16(ar_dx[15:0]),
    sext16(gb_dx[31:16]), sext16(gb_dx[15:0]),
    horiz_x_delta, vert_x_delta, mip_x_delta
  };
  wire [32*LANES-1:0] dy_bus = {
    setup_reg[`IDX_DEPTH_Y_DELTA],
    sext16(ar_dy[31:16]), sext16(ar_dy[15:0]),
    sext16(gb_dy[31:16]), sext16(gb_dy[15:0]),
    horiz_y_delta, vert_y_delta, mip_y_delta
  };

  // --------------------------------------------------------------------------
  // attribute accumulators
  // --------------------------------------------------------------------------
  wire [32*LANES-1:0] pixel_bus;

  genvar l;
  generate
    for (l = 0; l < LANES; l = l + 1) begin : lane
      reg  [31:0] line_acc;
      reg  [31:0] pixel_acc;
      wire [31:0] line_next = line_acc + dy_bus[l*32 +: 32];

      // load wins over a line step, a line step over a pixel step
      always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
          line_acc  <= `RESET_VALUE;
          pixel_acc <= `RESET_VALUE;
        end else if (attr_load) begin
          line_acc  <= start_bus[l*32 +: 32];
          pixel_acc <= start_bus[l*32 +: 32];
        end else if (attr_y_step) begin
          line_acc  <= line_next;
          pixel_acc <= line_next;
        end else if (attr_x_step) begin
          pixel_acc <= pixel_acc + dx_bus[l*32 +: 32];
        end
      end

      assign pixel_bus[l*32 +: 32] = pixel_acc;
    end
  endgenerate

  wire [31:0] mip_acc   = pixel_bus[0*32 +: 32];
  wire [31:0] vert_acc  = pixel_bus[1*32 +: 32];
  wire [31:0] horiz_acc = pixel_bus[2*32 +: 32];

  // --------------------------------------------------------------------------
  // step counters for the status word
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      x_step_count <= 16'h0000;
      y_step_count <= 16'h0000;
    end else if (attr_load) begin
      x_step_count <= 16'h0000;
      y_step_count <= 16'h0000;
    end else if (attr_y_step) begin
      y_step_count <= y_step_count + 16'h0001;
    end else if (attr_x_step) begin
      x_step_count <= x_step_count + 16'h0001;
    end
  end

  // --------------------------------------------------------------------------
  // registered attribute outputs
  // --------------------------------------------------------------------------
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mip_level          <= 8'h00;
      mip_wrap_limit     <= 4'h0;
      texel_vert_coord   <= 24'h00_0000;
      texel_vert_filter  <= 8'h00;
      texel_horiz_coord  <= 24'h00_0000;
      texel_horiz_filter <= 8'h00;
      blue_value         <= 16'h0000;
      green_value        <= 16'h0000;
      red_value          <= 16'h0000;
      alpha_value        <= 16'h0000;
      depth_value        <= `RESET_VALUE;
      perspective_active <= 1'b0;
    end else begin
      mip_level          <= mip_acc[`MIP_INT_MSB:`MIP_INT_LSB];
      mip_wrap_limit     <= wrap_en ? mip_acc[`MIP_WRAP_MSB:`MIP_WRAP_LSB] : 4'h0;
      perspective_active <= persp;
      if (persp) begin
        texel_vert_coord   <= vert_acc[`PERSP_INT_MSB:`PERSP_INT_LSB];
        texel_vert_filter  <= 8'h00;
        texel_horiz_coord  <= horiz_acc[`PERSP_INT_MSB:`PERSP_INT_LSB];
        texel_horiz_filter <= 8'h00;
      end else begin
        texel_vert_coord   <= {12'h000, vert_acc[`LINEAR_INT_MSB:`LINEAR_INT_LSB]};
        texel_vert_filter  <= vert_acc[`LINEAR_FILT_MSB:`LINEAR_FILT_LSB];
        texel_horiz_coord  <= {12'h000, horiz_acc[`LINEAR_INT_MSB:`LINEAR_INT_LSB]};
        texel_horiz_filter <= horiz_acc[`LINEAR_FILT_MSB:`LINEAR_FILT_LSB];
      end
      blue_value         <= pixel_bus[3*32 +: 16];
      green_value        <= pixel_bus[4*32 +: 16];
      red_value          <= pixel_bus[5*32 +: 16];
      alpha_value        <= pixel_bus[6*32 +: 16];
      depth_value        <= pixel_bus[7*32 +: 32];
    end
  end

endmodule // attr_setup_regs

// ===== testbench/attr_setup_regs_properties.sv
`timescale 1ns/1ns
// ------------------------------------------
// bus handshake and attribute output checks
// ------------------------------------------
module attr_setup_checker (
  input wire        clk,
  input wire        reset_n,
  input wire        s_axi_awvalid,
  input wire        s_axi_awready,
  input wire        s_axi_wvalid,
  input wire        s_axi_wready,
  input wire [1:0]  s_axi_bresp,
  input wire        s_axi_bvalid,
  input wire        s_axi_bready,
  input wire        s_axi_arvalid,
  input wire        s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire        s_axi_rvalid,
  input wire        s_axi_rready,
  input wire        attr_load,
  input wire [23:0] texel_vert_coord,
  input wire [7:0]  texel_vert_filter,
  input wire        perspective_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  b_answer_a: assert property (
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> ##1 s_axi_bvalid)
    else $error("write response not two cycles after take");
  b_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  b_release_a: assert property (
    s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
    else $error("write channel not freed after response");
  aw_block_a: assert property (
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken while response pending");
  r_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read data not one cycle after take");
  r_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data changed while waiting");
  r_release_a: assert property (
    s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read channel not freed");
  persp_filter_a: assert property (
    $past(attr_load, 2) && perspective_active |-> texel_vert_filter == 8'h00)
    else $error("filter bits shown under perspective");
  linear_coord_a: assert property (
    $past(attr_load, 2) && !perspective_active |-> texel_vert_coord[23:12] == 12'h000)
    else $error("linear coordinate not zero extended");

  write_c: cover property (s_axi_bvalid && s_axi_bready);
  refuse_c: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  persp_c: cover property (attr_load ##2 perspective_active);
endmodule // attr_setup_checker

bind attr_setup_regs attr_setup_checker attr_setup_checker_i (
  .clk(clk), .reset_n(reset_n), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .attr_load(attr_load),
  .texel_vert_coord(texel_vert_coord), .texel_vert_filter(texel_vert_filter),
  .perspective_active(perspective_active));

// ===== testbench/attr_setup_regs_test.sv
`timescale 1ns/1ns
`include "attr_setup_defs.vh"
module attr_setup_regs_test;
  reg         clk, reset_n, aw_v, w_v, b_r, ar_v, r_r, ld, xs, ys, p, w;
  reg  [15:0] aw_a, ar_a;
  reg  [31:0] w_d;
  reg  [3:0]  w_s;
  reg  [31:0] dl [0:5];
  reg  [31:0] pat [0:11];
  reg  [31:0] st [0:5], dx [0:5], dy [0:5], ln [0:5], px [0:5], ctl [0:3];
  wire        aw_rdy, w_rdy, b_v, ar_rdy, r_v, persp;
  wire [1:0]  b_rs, r_rs;
  wire [31:0] r_d, depth;
  wire [7:0]  mip, vf, hf;
  wire [3:0]  wrap;
  wire [23:0] vc, hc;
  wire [15:0] blue, green, red, alpha;
  integer     failures, comparisons, cycles, i, n;

  attr_setup_regs attr_setup_regs_i (.clk(clk), .reset_n(reset_n), .s_axi_awaddr(aw_a),
    .s_axi_awvalid(aw_v), .s_axi_awready(aw_rdy), .s_axi_wdata(w_d), .s_axi_wstrb(w_s),
    .s_axi_wvalid(w_v), .s_axi_wready(w_rdy), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v),
    .s_axi_bready(b_r), .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_rdy),
    .s_axi_rdata(r_d), .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r),
    .mip_x_delta(dl[0]), .mip_y_delta(dl[1]), .vert_x_delta(dl[2]), .vert_y_delta(dl[3]),
    .horiz_x_delta(dl[4]), .horiz_y_delta(dl[5]), .attr_load(ld), .attr_x_step(xs),
    .attr_y_step(ys), .mip_level(mip), .mip_wrap_limit(wrap), .texel_vert_coord(vc),
    .texel_vert_filter(vf), .texel_horiz_coord(hc), .texel_horiz_filter(hf),
    .blue_value(blue), .green_value(green), .red_value(red), .alpha_value(alpha),
    .depth_value(depth), .perspective_active(persp));

  // ------------------------------------------
  // checking and bus tasks
  // ------------------------------------------
  task results;
    begin
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
    end
  endtask

  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  // bready and rready rise only once the answer is seen, so the slave must hold it
  task axi_write(input [15:0] a, input [31:0] d, input [3:0] s, input [1:0] er);
    reg ah, wh, bh, bp;
    begin
      @(posedge clk);
      aw_a <= a;
      w_d <= d;
      w_s <= s;
      aw_v <= 1'h1;
      w_v <= 1'h1;
      bh = 1'h0;
      while (!bh) begin
        @(negedge clk);
        ah = aw_v && aw_rdy;
        wh = w_v && w_rdy;
        bh = b_v && b_r;
        bp = b_v;
        if (bh) check(b_rs, er);
        @(posedge clk);
        if (ah) aw_v <= 1'h0;
        if (wh) w_v <= 1'h0;
        if (bh) b_r <= 1'h0;
        else if (bp) b_r <= 1'h1;
      end
    end
  endtask

  task axi_read(input [15:0] a, input [31:0] ed, input [1:0] er);
    reg ah, rh, rp;
    begin
      @(posedge clk);
      ar_a <= a;
      ar_v <= 1'h1;
      rh = 1'h0;
      while (!rh) begin
        @(negedge clk);
        ah = ar_v && ar_rdy;
        rh = r_v && r_r;
        rp = r_v;
        if (rh) check(r_d, ed);
        if (rh) check(r_rs, er);
        @(posedge clk);
        if (ah) ar_v <= 1'h0;
        if (rh) r_r <= 1'h0;
        else if (rp) r_r <= 1'h1;
      end
    end
  endtask

  // colour words accumulate per half-word lane
  function [31:0] addk(input integer k, input [31:0] a, input [31:0] b);
    addk = (k == 3 || k == 4) ? {a[31:16] + b[31:16], a[15:0] + b[15:0]} : a + b;
  endfunction

  task pulse(input integer kind);
    integer j;
    begin
      @(posedge clk);
      ld <= (kind == 0);
      xs <= (kind == 1);
      ys <= (kind == 2);
      @(posedge clk);
      ld <= 1'h0;
      xs <= 1'h0;
      ys <= 1'h0;
      @(posedge clk);
      #1;
      for (j = 0; j < 6; j = j + 1) begin
        if (kind == 0) ln[j] = st[j];
        if (kind == 2) ln[j] = addk(j, ln[j], dy[j]);
        px[j] = (kind == 1) ? addk(j, px[j], dx[j]) : ln[j];
      end
      check(mip, px[0][26:19]);
      check(wrap, w ? px[0][30:27] : 4'h0);
      check(vc, p ? px[1][30:7] : {12'h000, px[1][30:19]});
      check(vf, p ? 8'h00 : px[1][18:11]);
      check(hc, p ? px[2][30:7] : {12'h000, px[2][30:19]});
      check(hf, p ? 8'h00 : px[2][18:11]);
      check({green, blue}, px[3]);
      check({alpha, red}, px[4]);
      check(depth, px[5]);
      check(persp, p);
    end
  endtask

  // ------------------------------------------
  // clock, timeout and test sequence
  // ------------------------------------------
  initial begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      failures = failures + 1;
      results;
    end
  end

  initial begin
    {aw_v, w_v, b_r, ar_v, r_r, ld, xs, ys, reset_n} = 9'h000;
    {aw_a, ar_a, w_d, w_s} = 68'h0;
    {failures, comparisons, cycles} = 96'h0;
    dl = '{32'h0008_0000, 32'h0010_0000, 32'h0000_0800, 32'h0008_0000, 32'h0000_1000,
      32'h0010_0000};
    pat = '{32'h1828_0000, 32'h091a_2800, 32'h0054_0000, 32'hfff0_0010, 32'h0001_ffff,
      32'h0020_0000, 32'h0000_0040, 32'h0100_0080, 32'h3f80_0200, 32'hffff_fff0,
      32'h0000_0100, 32'h0000_1000};
    st = '{pat[0], pat[1], pat[2], pat[7], pat[8], pat[11]};
    dx = '{dl[0], dl[2], dl[4], pat[3], pat[4], pat[9]};
    dy = '{dl[1], dl[3], dl[5], pat[5], pat[6], pat[10]};
    ctl = '{32'h0400_0000, 32'h2800_0000, 32'h3400_0000, 32'h2000_0000};
    repeat (10) @(posedge clk);
    reset_n <= 1'h1;
    for (i = 0; i < 12; i = i + 1) axi_read(16'(16'hb530 + 4 * i), 32'h0, `RESP_OKAY);
    for (i = 0; i < 12; i = i + 1)
      axi_write(16'(16'hb530 + 4 * i), pat[i], 4'hf, `RESP_OKAY);
    for (i = 0; i < 12; i = i + 1)
      axi_read(16'(16'hb530 + 4 * i), pat[i], `RESP_OKAY);
    axi_write(`ADDR_DEPTH_X_DELTA, 32'h1234_fff0, 4'h3, `RESP_OKAY);
    axi_read(`ADDR_DEPTH_X_DELTA, pat[9], `RESP_OKAY);
    axi_write(16'hb564, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    axi_read(16'hb564, 32'h0, `RESP_SLVERR);
    axi_write(16'hb532, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    axi_write(`ADDR_ATTR_STATUS, 32'hffff_ffff, 4'hf, `RESP_SLVERR);
    axi_read(`ADDR_MIP_LEVEL_START, pat[0], `RESP_OKAY);
    for (n = 0; n < 4; n = n + 1) begin
      axi_write(`ADDR_ATTR_CONTROL, ctl[n], 4'hf, `RESP_OKAY);
      axi_read(`ADDR_ATTR_CONTROL, ctl[n], `RESP_OKAY);
      p = (ctl[n][30:27] == 4'h5) || (ctl[n][30:27] == 4'h6);
      w = ctl[n][26];
      pulse(0);
      pulse(1);
      pulse(2);
      pulse(1);
      axi_read(`ADDR_ATTR_STATUS, 32'h0001_0002, `RESP_OKAY);
    end
    results;
  end
endmodule // attr_setup_regs_test
